/* pkg/flash_reset_regs.vh */
// Purpose: timing constants for the flash reset sequencing controller
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   times in their printed units, cycle counts derived from them
`ifndef FLASH_RESET_REGS_VH
`define FLASH_RESET_REGS_VH

`define CLK_PERIOD_PS                 5000
// supply setup waits, microseconds
`define CORE_SUPPLY_SETUP_TIME_US     300
`define IO_SUPPLY_SETUP_TIME_US       300
// reset low to select, microseconds
`define RESET_LOW_TO_SELECT_TIME_US   35
// reset pulse minimum, nanoseconds
`define RESET_PULSE_MIN_WIDTH_NS      200
// reset release to select, nanoseconds
`define RESET_RELEASE_TO_SELECT_NS    50

// least times round up to whole cycles
`define US_TO_CYC(t) (((t) * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NS_TO_CYC(t) (((t) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define SUPPLY_SETUP_CYC   `US_TO_CYC(`CORE_SUPPLY_SETUP_TIME_US)
`define RESET_TO_SEL_CYC   `US_TO_CYC(`RESET_LOW_TO_SELECT_TIME_US)
`define RESET_PULSE_CYC    `NS_TO_CYC(`RESET_PULSE_MIN_WIDTH_NS)
`define RELEASE_TO_SEL_CYC `NS_TO_CYC(`RESET_RELEASE_TO_SELECT_NS)

`define TIMER_W 20

`endif

/* core/wait_timer.v */
// Purpose: loadable down counter with a done level
// Assumes: single clock, async active-low reset
// Notes:   done is high while the count is zero
`timescale 1ns/10ps
`default_nettype none
module wait_timer #(
    parameter W = 20
) (
    input  wire         sys_clk_i,
    input  wire         resetn_i,
    input  wire         load_i,     // load a new count
    input  wire [W-1:0] value_i,    // count to load
    output wire         done_o      // count has run out
);
    reg [W-1:0] count_reg;          // remaining cycles

    // ****************************************
    // counter
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= {W{1'b0}};
        end else if (load_i) begin
            count_reg <= value_i;
        end else if (count_reg != {W{1'b0}}) begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_o = (count_reg == {W{1'b0}});
endmodule // wait_timer
`default_nettype wire

/* core/flash_reset_sequencer.v */
// Purpose: host-side reset and power-up sequencer for a parallel flash
// Assumes: supply good inputs are asynchronous levels; 200 MHz clock
// Notes:   drives the flash reset pin and gates chip select to the access logic
`timescale 1ns/10ps
`default_nettype none
`include "flash_reset_regs.vh"

module flash_reset_sequencer #(
    parameter SUPPLY_SETUP_CYC = `SUPPLY_SETUP_CYC,   // shorten in simulation
    parameter RESET_TO_SEL_CYC = `RESET_TO_SEL_CYC
) (
    input  wire sys_clk_i,
    input  wire resetn_i,
    input  wire core_supply_ok_i,   // core supply above operating minimum
    input  wire io_supply_ok_i,     // io supply above operating minimum
    input  wire reset_req_i,        // request a warm reset, level
    input  wire access_req_i,       // access logic wants chip select low
    input  wire ready_busy_n_i,     // device ready/busy pin, low = busy
    output reg  flash_reset_n_o,    // device reset pin, active low
    output reg  flash_select_n_o,   // device chip select, active low
    output reg  ready_o,            // access path open
    output reg  device_busy_o       // synchronised device busy level
);
    // ****************************************
    // states
    // ****************************************
    localparam S_OFF     = 3'b000;  // supplies down
    localparam S_SUPPLY  = 3'b001;  // supply setup wait
    localparam S_RST_LOW = 3'b010;  // reset pin held low
    localparam S_RST_REC = 3'b011;  // reset released, recovery wait
    localparam S_READY   = 3'b100;  // accesses allowed

    reg [2:0] state_reg;            // sequencer state
    reg [2:0] state_next;
    reg [2:0] sup_meta_reg;         // first stage of supply/busy sync
    reg [2:0] sup_sync_reg;         // second stage
    reg       rst_seen_reg;         // reset asked for during supply wait
    reg       load;                 // reload timer
    reg [`TIMER_W-1:0] load_val;    // value to reload
    wire      t_done;               // timer expired
    wire      supplies_ok;          // both supplies good
    // release-to-select count, cut to the timer width on purpose
    localparam integer REL_CYC = `RELEASE_TO_SEL_CYC;

    // ****************************************
    // synchronisers for pin levels
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sup_meta_reg <= 3'h0;
            sup_sync_reg <= 3'h0;
        end else begin
            sup_meta_reg <= {ready_busy_n_i, io_supply_ok_i, core_supply_ok_i};
            sup_sync_reg <= sup_meta_reg;
        end
    end
    assign supplies_ok = sup_sync_reg[0] & sup_sync_reg[1];

    // ****************************************
    // reset hold length
    // ****************************************
    // the pin stays low for the longer of the requested hold and the
    // minimum pulse, so a shortened hold setting can never hand the
    // device a pulse too short to be honoured
    function [`TIMER_W-1:0] hold_cycles;
        input integer want;         // requested hold in cycles
        integer       longest;      // larger of request and minimum pulse
        begin
            longest     = (want > `RESET_PULSE_CYC) ? want : `RESET_PULSE_CYC;
            hold_cycles = longest[`TIMER_W-1:0];
        end
    endfunction

    wait_timer #(.W(`TIMER_W)) u_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .load_i    (load),
        .value_i   (load_val),
        .done_o    (t_done)
    );

    // ****************************************
    // next state; one timer serves every wait
    // ****************************************
    always @* begin
        state_next = state_reg;
        load       = 1'b0;
        load_val   = {`TIMER_W{1'b0}};
        if (!supplies_ok) begin
            // supply loss restarts the whole power-up sequence; the timer
            // is kept full meanwhile, so the pin stays low a whole pulse
            state_next = S_OFF;
            load       = 1'b1;
            load_val   = hold_cycles(0);
        end else begin
            case (state_reg)
                S_OFF: begin
                    // leave only once the pin has been low a full pulse
                    if (t_done) begin
                        state_next = S_SUPPLY;
                        load       = 1'b1;
                        load_val   = SUPPLY_SETUP_CYC[`TIMER_W-1:0];
                    end
                end
                S_SUPPLY: begin
                    // reset may be low here; device ignores it anyway, but a
                    // request seen at any time in the wait is kept to its end
                    if (t_done) begin
                        if (reset_req_i || rst_seen_reg) begin
                            // 35 us counts from the end of supply waits
                            state_next = S_RST_LOW;
                            load       = 1'b1;
                            load_val   = hold_cycles(RESET_TO_SEL_CYC);
                        end else begin
                            state_next = S_RST_REC;
                            load       = 1'b1;
                            load_val   = REL_CYC[`TIMER_W-1:0];
                        end
                    end
                end
                S_RST_LOW: begin
                    // hold the pin until the pulse has covered the whole
                    // 35 us window, so pulse plus release always suffices
                    if (t_done && !reset_req_i) begin
                        state_next = S_RST_REC;
                        load       = 1'b1;
                        load_val   = REL_CYC[`TIMER_W-1:0];
                    end
                end
                S_RST_REC: begin
                    if (reset_req_i) begin
                        state_next = S_RST_LOW;
                        load       = 1'b1;
                        load_val   = hold_cycles(RESET_TO_SEL_CYC);
                    end else if (t_done) begin
                        state_next = S_READY;
                    end
                end
                S_READY: begin
                    if (reset_req_i) begin
                        state_next = S_RST_LOW;
                        load       = 1'b1;
                        load_val   = hold_cycles(RESET_TO_SEL_CYC);
                    end
                end
                default: begin
                    state_next = S_OFF;
                end
            endcase
        end
    end

    // ****************************************
    // state and registered outputs
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg        <= S_OFF;
            rst_seen_reg     <= 1'b0;
            flash_reset_n_o  <= 1'b0;
            flash_select_n_o <= 1'b1;
            ready_o          <= 1'b0;
            device_busy_o    <= 1'b0;
        end else begin
            state_reg       <= state_next;
            // a request inside the supply wait is remembered to its end
            rst_seen_reg    <= (state_next == S_SUPPLY) &&
                               (reset_req_i || rst_seen_reg);
            // pin stays low in off, low and supply-with-request states;
            // every hold is at least the minimum pulse long
            flash_reset_n_o <= !((state_next == S_OFF) ||
                                 (state_next == S_RST_LOW) ||
                                 ((state_next == S_SUPPLY) &&
                                  (reset_req_i || rst_seen_reg)));
            // select only in ready; leaving ready raises select on the same edge the pin falls,
            // so the first access after any reset is a fresh falling edge
            flash_select_n_o <= !((state_next == S_READY) && access_req_i &&
                                  !reset_req_i);
            ready_o          <= (state_next == S_READY);
            // device busy seen while it runs its reset algorithms
            device_busy_o    <= !sup_sync_reg[2];
        end
    end
endmodule // flash_reset_sequencer
`default_nettype wire

/* verification/flash_reset_checker.sv */
// Purpose: port checker for flash_reset_sequencer
// Assumes: one clock domain, reset active low
// Notes:   bound to the design at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "flash_reset_regs.vh"
module flash_reset_checker #(parameter SUPPLY_SETUP_CYC = `SUPPLY_SETUP_CYC) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic core_supply_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic reset_req_i,
    input wire logic access_req_i,
    input wire logic ready_busy_n_i,
    input wire logic flash_reset_n_o,
    input wire logic flash_select_n_o,
    input wire logic ready_o,
    input wire logic device_busy_o
);
    // helper counts of cycles the reset pin has stood high and stood low
    logic [7:0] high_run_reg;   // saturating run of high samples
    logic [7:0] low_run_reg;    // saturating run of low samples
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_run_reg <= 8'h00;
            low_run_reg  <= 8'hFF;  // pin held low through reset counts as long
        end else begin
            high_run_reg <= !flash_reset_n_o ? 8'h00 :
                            (high_run_reg == 8'hFF) ? high_run_reg : high_run_reg + 8'h01;
            low_run_reg  <= flash_reset_n_o ? 8'h00 :
                            (low_run_reg == 8'hFF) ? low_run_reg : low_run_reg + 8'h01;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rel; $fell(flash_select_n_o) |-> high_run_reg >= `RELEASE_TO_SEL_CYC; endproperty
    a_rel: assert property (p_rel) else $error("select fell too soon");
    property p_pulse; $rose(flash_reset_n_o) |-> low_run_reg >= `RESET_PULSE_CYC; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse short");
    property p_sup; $rose(ready_o) |->
        $past(core_supply_ok_i, SUPPLY_SETUP_CYC) && $past(io_supply_ok_i, SUPPLY_SETUP_CYC);
    endproperty
    a_sup: assert property (p_sup) else $error("ready before supply wait");
    property p_fresh; $rose(ready_o) |-> $past(flash_select_n_o); endproperty
    a_fresh: assert property (p_fresh) else $error("select not idle at ready");
    property p_sel; !flash_select_n_o |-> ready_o && $past(access_req_i); endproperty
    a_sel: assert property (p_sel) else $error("select without grant");
    property p_req; reset_req_i |=> !ready_o; endproperty
    a_req: assert property (p_req) else $error("ready during reset");
    property p_loss; $fell(core_supply_ok_i) |-> ##[1:4] !flash_reset_n_o; endproperty
    a_loss: assert property (p_loss) else $error("supply loss ignored");
    property p_busy; $fell(ready_busy_n_i) |-> ##[2:4] device_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("busy not reported");
endmodule // flash_reset_checker
bind flash_reset_sequencer flash_reset_checker #(.SUPPLY_SETUP_CYC(SUPPLY_SETUP_CYC)) chk_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .core_supply_ok_i(core_supply_ok_i),
    .io_supply_ok_i(io_supply_ok_i), .reset_req_i(reset_req_i), .access_req_i(access_req_i),
    .ready_busy_n_i(ready_busy_n_i), .flash_reset_n_o(flash_reset_n_o),
    .flash_select_n_o(flash_select_n_o), .ready_o(ready_o), .device_busy_o(device_busy_o));
`default_nettype wire

/* verification/flash_dev_model.sv */
// Purpose: behavioural flash device seen by the reset sequencer
// Assumes: power good is both supplies in range
// Notes:   short counts stand in for the cold and warm reset times
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(parameter COLD_CYC = 50, parameter WARM_CYC = 20) (
    input  wire logic clk_i,          // bench clock, the device has none
    input  wire logic power_ok_i,     // both supplies in range
    input  wire logic reset_n_i,      // reset pin, active low
    output var  logic ready_busy_n_o  // low while resetting
);
    int   left_reg;   // reset cycles still to run
    logic rst_d_reg;  // reset pin one cycle ago
    // a running reset ignores the pins; a fall only counts once idle
    always @(posedge clk_i) begin
        rst_d_reg <= reset_n_i;
        if (!power_ok_i) left_reg <= COLD_CYC;
        else if (left_reg > 0) left_reg <= left_reg - 1;
        else if (rst_d_reg && !reset_n_i) left_reg <= WARM_CYC;
    end
    // busy through any reset, and held while the pin stays low
    always @* ready_busy_n_o = (left_reg == 0) && reset_n_i;
endmodule // flash_dev_model
`default_nettype wire

/* verification/test_flash_reset_sequencer.sv */
// Purpose: self-checking bench for flash_reset_sequencer
// Assumes: waits shortened to 50 and 20 cycles
// Notes:   device side is flash_dev_model
`timescale 1ns/10ps
`default_nettype none
module test_flash_reset_sequencer;
    logic sys_clk_i = 0, resetn_i = 0, core_ok = 0, io_ok = 0, rreq = 0, areq = 0;
    logic frn, fsn, rdy, busy, rbn;   // design and device outputs
    int   miscompares = 0, check_count = 0;
    localparam int PULSE_CYC = 40;   // 200 ns minimum pulse at 5 ns
    always #2.5 sys_clk_i = ~sys_clk_i;  // 200 MHz
    flash_reset_sequencer #(.SUPPLY_SETUP_CYC(50), .RESET_TO_SEL_CYC(20)) flash_reset_sequencer_i (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .core_supply_ok_i(core_ok),
        .io_supply_ok_i(io_ok), .reset_req_i(rreq), .access_req_i(areq), .ready_busy_n_i(rbn),
        .flash_reset_n_o(frn), .flash_select_n_o(fsn), .ready_o(rdy), .device_busy_o(busy));
    flash_dev_model flash_dev_model_i (.clk_i(sys_clk_i), .power_ok_i(core_ok && io_ok),
        .reset_n_i(frn), .ready_busy_n_o(rbn));
    task automatic check(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    // count settled cycles until ready, bounded so a hang shows up
    task automatic wait_ready(output int n);
        n = 0;
        while (rdy !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_i); #1; n++;
        end
    endtask
    task automatic power_up;
        int n;
        @(posedge sys_clk_i); core_ok <= 1; io_ok <= 1;
        wait_ready(n);
        check(n >= 50 && n < 2000, "ready timing");
        check(fsn === 1'b1 && rbn === 1'b1, "not idle");
        @(posedge sys_clk_i); areq <= 1;
        repeat (2) @(posedge sys_clk_i); #1;
        check(fsn === 1'b0, "select did not follow");
        @(posedge sys_clk_i); areq <= 0;
    endtask
    task automatic warm_reset;
        int n;
        @(posedge sys_clk_i); rreq <= 1;
        repeat (2) @(posedge sys_clk_i); #1;
        check(frn === 1'b0 && rdy === 1'b0, "pin not low");
        repeat (8) @(posedge sys_clk_i); #1;
        check(busy === 1'b1, "busy not seen");
        @(posedge sys_clk_i); rreq <= 0; areq <= 1;
        n = 0;
        while (frn !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i); #1; n++;
        end
        check(n + 10 >= PULSE_CYC && n < 100, "pulse length");
        wait_ready(n);
        check(n >= 10 && busy === 1'b0, "release timing");
        check(fsn === 1'b0, "select not granted");
        @(posedge sys_clk_i); areq <= 0;
    endtask
    task automatic reset_in_power;
        int n;
        @(posedge sys_clk_i); core_ok <= 0; rreq <= 1;
        repeat (6) @(posedge sys_clk_i); #1;
        check(frn === 1'b0 && rdy === 1'b0, "loss ignored");
        @(posedge sys_clk_i); core_ok <= 1;
        repeat (90) @(posedge sys_clk_i); #1;
        check(frn === 1'b0 && busy === 1'b1, "pin freed");
        @(posedge sys_clk_i); rreq <= 0;
        wait_ready(n);
        check(n >= 20 && n < 2000, "late ready");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        resetn_i <= 1;
        power_up;
        warm_reset;
        reset_in_power;
        close_out;
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule // test_flash_reset_sequencer
`default_nettype wire
